// File: shared/uart_status_pkg.sv
// What this block does
// RQ1 - set the overrun flag, status bit 0, when a character arrives before the last was taken.
// RQ2 - set the parity error flag, status bit 1, when a character fails its parity check.
// RQ3 - set the frame error flag, status bit 2, when a character has a bad stop bit.
// RQ4 - set the break flag, status bit 3, when a break is seen on the receive line.
// RQ5 - clear all four receive error flags as a side effect of any status read.
// RQ6 - raise the receive status interrupt on any receive error while its enable bit is 1.
// RQ7 - status bit 5 is 1 while the receive holding buffer holds a valid character.
// RQ8 - status bit 6 is 1 while the transmit holding buffer is empty, 0 while a character waits.
// RQ9 - software writes the transmit holding buffer only while bit 6 reads 1.
// RQ10 - status bit 7 is 1 only when holding buffer and shift register are both empty.
// RQ11 - the status register is read-only and reads with both transmit empty flags set after reset.
// RQ12 - status bit 4 reads zero and writes to the status register do nothing.
// RQ13 - a write to the transmit holding buffer clears the holding empty flag.
package uart_status_pkg;
   localparam logic [15:0] status_addr  = 16'h500b;
   localparam logic [15:0] control_addr = 16'h5007;
   localparam logic [15:0] irq_stat_addr = 16'h5020;
   localparam logic [15:0] irq_en_addr  = 16'h5024;
   localparam logic [15:0] irq_clr_addr = 16'h5028;
   localparam logic [7:0]  status_reset = 8'hc0;
   localparam logic [7:0]  zero_byte    = 8'h00;
   localparam int          ctl_rx_irq_bit = 2;
   localparam logic [3:0]  irq_zero     = 4'h0;
   // error flag positions, shared by the status word and the pending word
   localparam int          overrun_bit  = 0;
   localparam int          parity_bit   = 1;
   localparam int          frame_bit    = 2;
   localparam int          break_bit    = 3;

   typedef struct packed {
      logic tx_empty;
      logic hold_empty;
      logic rx_ready;
      logic unused;
      logic brk;
      logic frame;
      logic parity;
      logic overrun;
   } line_status_flags_type;

   // receive event pulses from the receive datapath
   typedef struct packed {
      logic char_done;
      logic parity_err;
      logic frame_err;
      logic brk;
   } rx_event_type;
endpackage

// File: logic/uart_err_flags.sv
`timescale 1ns/1ns
// four sticky error flags, set over clear
module uart_err_flags (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // events and clear
   input  wire logic [3:0] i_set,
   input  wire logic [3:0] i_clr,
   // flags
   output logic      [3:0] o_flags
);
   logic [3:0] next_flags;

   // set wins so an event in the clearing cycle survives
   always_comb begin
      next_flags = (o_flags & ~i_clr) | i_set;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flags <= uart_status_pkg::irq_zero;
      end else begin
         o_flags <= next_flags;
      end
   end

   a_set_wins_clear: assert property ( // see RQ5
      @(posedge i_sys_clk) disable iff (i_rst)
      |i_set |-> ##1 ((o_flags & $past(i_set)) == $past(i_set)))
      else $error("sticky flag lost its set");
endmodule

// File: logic/uart_tx_track.sv
`timescale 1ns/1ns
// holding buffer and shift register occupancy
module uart_tx_track (
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   // transmit events
   input  wire logic i_hold_write,
   input  wire logic i_shift_load,
   input  wire logic i_shift_done,
   // flags
   output logic      o_hold_empty,
   output logic      o_tx_empty
);
   logic hold_full;
   logic shift_busy;
   logic next_hold_full;
   logic next_shift_busy;

   // a write in the load cycle refills the buffer
   always_comb begin
      next_hold_full  = i_hold_write | (hold_full & ~i_shift_load); // see RQ13
      next_shift_busy = i_shift_load | (shift_busy & ~i_shift_done);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_full  <= 1'b0;
         shift_busy <= 1'b0;
      end else begin
         hold_full  <= next_hold_full;
         shift_busy <= next_shift_busy;
      end
   end

   assign o_hold_empty = ~hold_full; // see RQ8
   assign o_tx_empty   = ~hold_full & ~shift_busy; // see RQ10

   a_write_clears_hold: assert property ( // see RQ13
      @(posedge i_sys_clk) disable iff (i_rst)
      i_hold_write |=> !o_hold_empty)
      else $error("holding empty not cleared by write");
   a_tx_empty_both: assert property ( // see RQ10
      @(posedge i_sys_clk) disable iff (i_rst)
      o_tx_empty |-> o_hold_empty)
      else $error("transmitter empty with data held");
endmodule

// File: logic/uart_line_status_flags.sv
`timescale 1ns/1ns
// line status register, receive error interrupt and register port
module uart_line_status_flags (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // register port
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // receive datapath
   input  wire uart_status_pkg::rx_event_type i_rx_event,
   input  wire logic        i_rx_taken,
   // transmit datapath
   input  wire logic        i_hold_write,
   input  wire logic        i_shift_load,
   input  wire logic        i_shift_done,
   // interrupt
   output logic             o_irq
);
   logic [7:0] control;
   logic [3:0] irq_enable;
   logic       rx_ready;
   logic [7:0] rdata;
   logic [7:0] next_control;
   logic [3:0] next_irq_enable;
   logic       next_rx_ready;
   logic [7:0] next_rdata;
   logic [3:0] err_set;
   logic [3:0] err_clr;
   logic [3:0] err_flags;
   logic [3:0] irq_set;
   logic [3:0] irq_clr;
   logic [3:0] irq_pend;
   logic       hold_empty;
   logic       tx_empty;
   logic       status_rd;
   uart_status_pkg::line_status_flags_type status;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a == r);
   endfunction

   assign status_rd = i_rd & hit(i_addr, uart_status_pkg::status_addr);

   // error events; overrun when a character lands on an untaken one
   always_comb begin
      err_set[uart_status_pkg::overrun_bit] =
         i_rx_event.char_done & rx_ready & ~i_rx_taken; // see RQ1
      err_set[uart_status_pkg::parity_bit] = i_rx_event.parity_err; // see RQ2
      err_set[uart_status_pkg::frame_bit]  = i_rx_event.frame_err; // see RQ3
      err_set[uart_status_pkg::break_bit]  = i_rx_event.brk; // see RQ4
      err_clr    = {4{status_rd}}; // see RQ5
      irq_set    = control[uart_status_pkg::ctl_rx_irq_bit] ? err_set
                                                            : uart_status_pkg::irq_zero; // see RQ6
      irq_clr    = (i_wr & hit(i_addr, uart_status_pkg::irq_clr_addr)) ? i_wdata[3:0]
                                                                        : uart_status_pkg::irq_zero;
   end

   uart_err_flags u_err (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_set     (err_set),
      .i_clr     (err_clr),
      .o_flags   (err_flags)
   );

   // pending receive status interrupts, cleared by write-one
   uart_err_flags u_irq (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_set     (irq_set),
      .i_clr     (irq_clr),
      .o_flags   (irq_pend)
   );

   uart_tx_track u_tx (
      .i_sys_clk    (i_sys_clk),
      .i_rst        (i_rst),
      .i_hold_write (i_hold_write),
      .i_shift_load (i_shift_load),
      .i_shift_done (i_shift_done),
      .o_hold_empty (hold_empty),
      .o_tx_empty   (tx_empty)
   );

   // assembled status word; bit 4 held at zero
   always_comb begin
      status.overrun    = err_flags[uart_status_pkg::overrun_bit];
      status.parity     = err_flags[uart_status_pkg::parity_bit];
      status.frame      = err_flags[uart_status_pkg::frame_bit];
      status.brk        = err_flags[uart_status_pkg::break_bit];
      status.unused     = 1'b0; // see RQ12
      status.rx_ready   = rx_ready; // see RQ7
      status.hold_empty = hold_empty; // see RQ8
      status.tx_empty   = tx_empty; // see RQ10
   end

   // register writes and read mux; status has no write path
   always_comb begin
      next_control    = control;
      next_irq_enable = irq_enable;
      next_rx_ready   = i_rx_event.char_done | (rx_ready & ~i_rx_taken); // see RQ7
      next_rdata      = uart_status_pkg::zero_byte;
      if (i_wr && hit(i_addr, uart_status_pkg::control_addr)) begin
         next_control = i_wdata;
      end
      if (i_wr && hit(i_addr, uart_status_pkg::irq_en_addr)) begin
         next_irq_enable = i_wdata[3:0];
      end
      if (i_rd) begin
         if (hit(i_addr, uart_status_pkg::status_addr)) begin
            next_rdata = status; // see RQ11
         end else if (hit(i_addr, uart_status_pkg::control_addr)) begin
            next_rdata = control;
         end else if (hit(i_addr, uart_status_pkg::irq_stat_addr)) begin
            next_rdata = {uart_status_pkg::irq_zero, irq_pend};
         end else if (hit(i_addr, uart_status_pkg::irq_en_addr)) begin
            next_rdata = {uart_status_pkg::irq_zero, irq_enable};
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         control    <= uart_status_pkg::zero_byte;
         irq_enable <= uart_status_pkg::irq_zero;
         rx_ready   <= 1'b0;
         rdata      <= uart_status_pkg::zero_byte;
      end else begin
         control    <= next_control;
         irq_enable <= next_irq_enable;
         rx_ready   <= next_rx_ready;
         rdata      <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   // level output while any enabled pending bit stands
   assign o_irq   = |(irq_pend & irq_enable); // see RQ6

   // each receive event must show in the status word one cycle later
   a_overrun_set: assert property ( // see RQ1
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_rx_event.char_done && rx_ready && !i_rx_taken)
      |=> err_flags[uart_status_pkg::overrun_bit])
      else $error("overrun flag not set");
   a_parity_set: assert property ( // see RQ2
      @(posedge i_sys_clk) disable iff (i_rst)
      i_rx_event.parity_err |=> status.parity)
      else $error("parity flag not set");
   a_frame_set: assert property ( // see RQ3
      @(posedge i_sys_clk) disable iff (i_rst)
      i_rx_event.frame_err |=> status.frame)
      else $error("frame flag not set");
   a_break_set: assert property ( // see RQ4
      @(posedge i_sys_clk) disable iff (i_rst)
      i_rx_event.brk |=> status.brk)
      else $error("break flag not set");
   // a flag may only rise on an event, never on its own
   a_flag_needs_event: assert property ( // see RQ1
      @(posedge i_sys_clk) disable iff (i_rst)
      ((err_flags & ~$past(err_flags) & ~$past(err_set)) == uart_status_pkg::irq_zero))
      else $error("error flag rose without an event");
   a_read_clears: assert property ( // see RQ5
      @(posedge i_sys_clk) disable iff (i_rst)
      (status_rd && !(|err_set)) |=> (err_flags == uart_status_pkg::irq_zero))
      else $error("status read left an error flag");
   a_irq_on_error: assert property ( // see RQ6
      @(posedge i_sys_clk) disable iff (i_rst)
      (control[uart_status_pkg::ctl_rx_irq_bit] && (|err_set))
      |=> ((irq_pend & $past(err_set)) == $past(err_set)))
      else $error("error did not pend an interrupt");
   // with the gate off no new pending bit may appear
   a_irq_gated: assert property ( // see RQ6
      @(posedge i_sys_clk) disable iff (i_rst)
      !control[uart_status_pkg::ctl_rx_irq_bit]
      |=> ((irq_pend & ~$past(irq_pend)) == uart_status_pkg::irq_zero))
      else $error("pending bit set while gated off");
   a_read_returns: assert property ( // see RQ11
      @(posedge i_sys_clk) disable iff (i_rst)
      status_rd |=> (o_rdata == $past(status)) && !o_rdata[4])
      else $error("status read data wrong");
   // read data stand one cycle only, zero otherwise
   a_rdata_idle: assert property ( // see RQ11
      @(posedge i_sys_clk) disable iff (i_rst)
      !i_rd |=> (o_rdata == uart_status_pkg::zero_byte))
      else $error("read data outside the read cycle");
   a_status_write_ignored: assert property ( // see RQ12
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && hit(i_addr, uart_status_pkg::status_addr))
      |=> ($stable(control) && $stable(irq_enable)))
      else $error("status write changed a register");
   a_ready_follows: assert property ( // see RQ7
      @(posedge i_sys_clk) disable iff (i_rst)
      i_rx_event.char_done |=> status.rx_ready)
      else $error("receive ready not set");
   a_take_clears_ready: assert property ( // see RQ7
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_rx_taken && !i_rx_event.char_done) |=> !status.rx_ready)
      else $error("receive ready not cleared by take");
endmodule

// File: bench/uart_rx_peer.sv
`timescale 1ns/1ns
// far serial peer as seen through the receiver: one event pulse per character
module uart_rx_peer (
   // clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst,
   // request from the bench
   input  wire logic                          i_send,
   input  wire logic [3:0]                    i_kind,
   // receive events toward the design
   output uart_status_pkg::rx_event_type      o_event
);
   // registered so events never share an edge with the request
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event <= '0;
      end else begin
         o_event <= i_send ? uart_status_pkg::rx_event_type'(i_kind) : '0;
      end
   end
endmodule

// File: bench/uart_line_status_flags_bench.sv
`timescale 1ns/1ns
module uart_line_status_flags_bench;
   logic                          i_sys_clk = 1'b0;
   logic                          i_rst = 1'b1;
   logic [15:0]                   i_addr = 16'h0000;
   logic [7:0]                    i_wdata = 8'h00;
   logic                          i_wr = 1'b0;
   logic                          i_rd = 1'b0;
   logic [3:0]                    tx = 4'h0;
   logic                          send = 1'b0;
   logic [3:0]                    kind = 4'h0;
   logic [7:0]                    o_rdata;
   logic                          o_irq;
   uart_status_pkg::rx_event_type rx_event;
   int                            n_errors = 0;
   int                            checks = 0;
   logic [7:0]                    exp_st;
   logic [7:0]                    got;
   logic [3:0]                    exp_pend = 4'h0;
   logic [3:0]                    exp_en = 4'h0;
   logic                          ctl_on = 1'b0;

   always #2 i_sys_clk = ~i_sys_clk;

   uart_rx_peer peer (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_send(send), .i_kind(kind),
      .o_event(rx_event));
   uart_line_status_flags dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_event(rx_event),
      .i_rx_taken(tx[3]), .i_hold_write(tx[0]), .i_shift_load(tx[1]), .i_shift_done(tx[2]),
      .o_irq(o_irq));

   // error flags an event should raise: brk, frame, parity, overrun
   function automatic logic [3:0] errs_of(input logic [3:0] k, input logic ready);
      return {k[0], k[1], k[2], k[3] & ready};
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // a status read clears the four error flags in the model too
   task automatic rd_status(input string what);
      rd(uart_status_pkg::status_addr, got);
      chk(what, exp_st, got);
      exp_st[3:0] = 4'h0;
   endtask
   task automatic rx_ev(input logic [3:0] k);
      logic [3:0] e;
      e = errs_of(k, exp_st[5]);
      @(posedge i_sys_clk);
      send <= 1'b1; kind <= k;
      @(posedge i_sys_clk);
      send <= 1'b0;
      @(posedge i_sys_clk);
      exp_st[3:0] = exp_st[3:0] | e;
      if (k[3]) exp_st[5] = 1'b1;
      if (ctl_on) exp_pend = exp_pend | e;
   endtask
   // transmit and take pulses, one cycle each
   task automatic pulse(input int which);
      @(posedge i_sys_clk);
      tx[which] <= 1'b1;
      @(posedge i_sys_clk);
      tx <= 4'h0;
   endtask
   task automatic chk_irq();
      @(posedge i_sys_clk);
      #1 chk("irq", {7'h00, |(exp_pend & exp_en)}, {7'h00, o_irq});
   endtask

   task automatic results();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #20000;
      n_errors++;
      results();
   end

   initial begin
      void'($urandom(32'heb86d6e5));
      exp_st = uart_status_pkg::status_reset;
      repeat (3) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rd_status("status reset");
      wr(uart_status_pkg::status_addr, 8'hff);
      rd_status("status after write");
      wr(uart_status_pkg::irq_en_addr, 8'h0f);
      exp_en = 4'hf;
      for (int k = 0; k < 3; k++) begin
         rx_ev(4'h1 << k);
         rd_status("status error set");
         rd_status("status error cleared");
      end
      chk_irq();
      rx_ev(4'h8);
      rd_status("status rx ready");
      rx_ev(4'h8);
      rd_status("status overrun");
      pulse(3);
      exp_st[5] = 1'b0;
      rd_status("status taken");
      // hold write only while the holding buffer reads empty
      pulse(0);
      exp_st[7:6] = 2'b00;
      rd_status("status hold written");
      pulse(1);
      exp_st[6] = 1'b1;
      rd_status("status shift loaded");
      pulse(2);
      exp_st[7] = 1'b1;
      rd_status("status shift done");
      wr(uart_status_pkg::control_addr, 8'h04);
      ctl_on = 1'b1;
      rx_ev(4'h2);
      chk_irq();
      rd_status("status frame");
      chk_irq();
      rd(uart_status_pkg::irq_stat_addr, got);
      chk("irq status", {4'h0, exp_pend}, got);
      // mask the frame source: pending stays, the line must drop
      wr(uart_status_pkg::irq_en_addr, 8'h0b);
      exp_en = 4'hb;
      chk_irq();
      rd(uart_status_pkg::irq_en_addr, got);
      chk("irq enable", 8'h0b, got);
      rd(uart_status_pkg::control_addr, got);
      chk("control", 8'h04, got);
      wr(uart_status_pkg::irq_en_addr, 8'h0f);
      exp_en = 4'hf;
      chk_irq();
      wr(uart_status_pkg::irq_clr_addr, 8'h0f);
      exp_pend = 4'h0;
      chk_irq();
      rd(16'h5030, got);
      chk("unmapped read", 8'h00, got);
      // random mix of receive events, reads and takes
      repeat (60) begin
         case ($urandom_range(0, 3))
            0: rx_ev(4'($urandom));
            1: rd_status("status random");
            2: begin
               pulse(3);
               exp_st[5] = 1'b0;
            end
            default: chk_irq();
         endcase
      end
      results();
   end
endmodule
